// file: logic/pdc_pkg.sv
// Purpose: Shared constants, register map and address decoding for the port direction control.
// Assumes: 32-bit AXI4-Lite register access, one register per aligned word, data in bits 7:0 (bit operation word: bits 10:0).
// Notes:   Register indices are kept as printed; a byte address is four times the index.
`default_nettype none
package pdc_pkg;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Port table. Entry 0 is port 4; entries 1 to 6 are ports 3, 7, 8, 9, 10 and 12.
  localparam int          PDC_NPORT = 7;

  localparam logic [31:0] PDC_DIR_IDX [PDC_NPORT] = '{
    32'h000FFF24, 32'h000FFF23, 32'h000FFF27, 32'h000FFF28,
    32'h000FFF29, 32'h000FFF2A, 32'h000FFF2C};

  // Writes set the output latch; reads return the pin level seen by software.
  localparam logic [31:0] PDC_LATCH_IDX [PDC_NPORT] = '{
    32'h000FFF04, 32'h000FFF03, 32'h000FFF07, 32'h000FFF08,
    32'h000FFF09, 32'h000FFF0A, 32'h000FFF0C};

  // Bits with a pin behind them.
  localparam logic [7:0]  PDC_IMPL_MASK [PDC_NPORT] = '{
    8'hFF, 8'h18, 8'h1F, 8'hFF, 8'hFF, 8'h3F, 8'h21};

  // Bits that can serve as analog inputs; port 4 has none.
  localparam logic [7:0]  PDC_ANALOG_MASK [PDC_NPORT] = '{
    8'h00, 8'h18, 8'h1F, 8'hFF, 8'hFF, 8'h3F, 8'h21};

  localparam logic [31:0] PDC_PULLUP_IDX = 32'h000F0034;
  localparam logic [31:0] PDC_THRESH_IDX = 32'h000F0064;
  localparam logic [31:0] PDC_BITOP_IDX  = 32'h000F0080;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Reset values and field layouts.
  localparam logic [7:0]  PDC_DIR_RESET    = 8'hFF;
  localparam logic [7:0]  PDC_LATCH_RESET  = 8'h00;
  localparam logic [7:0]  PDC_PULLUP_RESET = 8'h00;
  localparam logic [7:0]  PDC_THRESH_RESET = 8'h00;
  localparam logic [7:0]  PDC_THRESH_MASK  = 8'h08;
  localparam int          PDC_THRESH_BIT   = 3;

  localparam int          PDC_BITOP_POS_LSB = 0;
  localparam int          PDC_BITOP_VAL_BIT = 3;
  localparam int          PDC_BITOP_SEL_LSB = 8;

  localparam logic [1:0]  PDC_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  PDC_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PDC_K_NONE   = 3'h0,
    PDC_K_DIR    = 3'h1,
    PDC_K_LATCH  = 3'h2,
    PDC_K_PULLUP = 3'h3,
    PDC_K_THRESH = 3'h4,
    PDC_K_BITOP  = 3'h5
  } pdc_kind_type;

  ////////////////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] pdc_byte_addr(input logic [31:0] idx);
    return {idx[29:0], 2'h0};
  endfunction

  function automatic pdc_kind_type pdc_decode_kind(input logic [31:0] addr);
    pdc_kind_type k;
    k = PDC_K_NONE;
    for (int i = 0; i < PDC_NPORT; i++) begin
      if (addr == pdc_byte_addr(PDC_DIR_IDX[i])) k = PDC_K_DIR;
      if (addr == pdc_byte_addr(PDC_LATCH_IDX[i])) k = PDC_K_LATCH;
    end
    if (addr == pdc_byte_addr(PDC_PULLUP_IDX)) k = PDC_K_PULLUP;
    if (addr == pdc_byte_addr(PDC_THRESH_IDX)) k = PDC_K_THRESH;
    if (addr == pdc_byte_addr(PDC_BITOP_IDX)) k = PDC_K_BITOP;
    return k;
  endfunction

  function automatic logic [2:0] pdc_decode_port(input logic [31:0] addr);
    logic [2:0] p;
    p = 3'h0;
    for (int i = 0; i < PDC_NPORT; i++) begin
      if (addr == pdc_byte_addr(PDC_DIR_IDX[i]) || addr == pdc_byte_addr(PDC_LATCH_IDX[i])) begin
        p = 3'(i);
      end
    end
    return p;
  endfunction

endpackage
`default_nettype wire

// file: logic/pdc_pin_cell.sv
// Purpose: Pin drive, analog release and read-back for one 8-bit port.
// Assumes: Pin inputs are synchronous to clk.
// Notes:   All outputs are registered, so they follow a register change by one cycle.
`timescale 1ns/10ps
`default_nettype none
module pdc_pin_cell
  import pdc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] dir,
  input  wire logic [7:0] latch,
  input  wire logic [7:0] impl,
  input  wire logic [7:0] analog_cap,
  input  wire logic [7:0] pin_in,
  output logic      [7:0] pin_out,
  output logic      [7:0] pin_oe,
  output logic      [7:0] analog_en,
  output logic      [7:0] read_val
);

  logic [7:0] drive;
  logic [7:0] analog;

  // A set direction bit means input with the driver off; a clear bit drives the pin.
  assign drive  = impl & ~dir;
  assign analog = analog_cap & dir;

  ////////////////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_oe  <= 8'h00;
      pin_out <= 8'h00;
    end else begin
      pin_oe  <= drive;
      // The latch never reaches an analog pin because such a pin is never driven.
      pin_out <= latch & drive;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      analog_en <= 8'h00;
    end else begin
      analog_en <= analog;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      read_val <= 8'h00;
    end else begin
      // Analog pins read as zero so that software never sees a half-level as a logic value.
      read_val <= impl & ~analog & ((dir & pin_in) | (~dir & latch));
    end
  end

endmodule
`default_nettype wire

// file: logic/pdc_port_ctrl.sv
// Purpose: Direction, pull-up, threshold and analog release control for the port pins.
// Assumes: AXI4-Lite slave on mclk; pin inputs synchronous to mclk.
// Notes:   Pin outputs follow a register change by one cycle.
// Contract
// - Each port 4 pin is set alone: direction 1 is input, 0 is output.
// - Port 4 input pins get a pull-up from a per-bit pull-up register.
// - Port 4 pin 3 input threshold: 0 first Schmitt type, 1 third type.
// - Reset puts every port 4 pin into input mode.
// - An analog pin is an analog input only while its direction bit is 1.
// - An analog input ignores its output latch value.
// - Reading an analog input pin returns 0, not the pin level.
// - Direction registers take single-bit and whole-byte writes.
// - Reset loads every analog-capable direction register with all ones.
// - Direction 1 disables the output driver; 0 enables it.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module pdc_port_ctrl
  import pdc_pkg::*;
(
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        sys_rst,

  // Register bus, write side.
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,

  // Register bus, read side.
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,

  // Port 4 pins.
  input  wire logic [7:0]  port4_pins_in,
  output logic [7:0]       port4_pins_out,
  output logic [7:0]       port4_pins_oe,
  output logic [7:0]       port4_pullup_en,
  output logic             port4_pin3_schmitt3_sel,

  // Ports 3, 7, 8, 9, 10 and 12, low byte first.
  input  wire logic [47:0] aport_pins_in,
  output logic [47:0]      aport_pins_out,
  output logic [47:0]      aport_pins_oe,
  output logic [47:0]      aport_analog_en
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [PDC_NPORT-1:0][7:0] dir_reg;
  logic [PDC_NPORT-1:0][7:0] dir_next;
  logic [PDC_NPORT-1:0][7:0] latch_reg;

  // Pin cell wires.
  logic [PDC_NPORT-1:0][7:0] cell_read;
  logic [PDC_NPORT-1:0][7:0] cell_out;
  logic [PDC_NPORT-1:0][7:0] cell_oe;
  logic [PDC_NPORT-1:0][7:0] cell_analog;
  logic [PDC_NPORT-1:0][7:0] cell_in;

  // Port 4 input controls.
  logic [7:0]                pullup_reg;
  logic [7:0]                thresh_reg;
  logic [7:0]                pullup_en_reg;
  logic                      schmitt3_reg;

  // Write channel state.
  logic                      aw_full_reg;
  logic [31:0]               aw_addr_reg;
  logic                      w_full_reg;
  logic [31:0]               w_data_reg;
  logic [3:0]                w_strb_reg;
  logic                      bvalid_reg;
  logic [1:0]                bresp_reg;
  logic                      do_write;
  pdc_kind_type              wr_kind;
  logic [2:0]                wr_port;
  logic                      wr_byte0;
  logic [2:0]                bit_pos;
  logic                      bit_val;
  logic [2:0]                bit_sel;

  // Read channel state.
  logic                      rvalid_reg;
  logic [7:0]                rdata_reg;
  logic [1:0]                rresp_reg;
  pdc_kind_type              rd_kind;
  logic [2:0]                rd_port;
  logic [7:0]                rd_data_next;
  logic [1:0]                rd_resp_next;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Write address and data are held apart so that either may arrive first.
  // A commit waits for a pending response, so none is lost.
  assign s_axi_awready = ~aw_full_reg;
  assign s_axi_wready  = ~w_full_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign do_write      = aw_full_reg & w_full_reg & ~bvalid_reg;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_full_reg <= 1'b0;
    end else if (s_axi_awvalid && !aw_full_reg) begin
      aw_full_reg <= 1'b1;
    end else if (do_write) begin
      aw_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_addr_reg <= 32'h00000000;
    end else if (s_axi_awvalid && !aw_full_reg) begin
      aw_addr_reg <= s_axi_awaddr;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      w_full_reg <= 1'b0;
    end else if (s_axi_wvalid && !w_full_reg) begin
      w_full_reg <= 1'b1;
    end else if (do_write) begin
      w_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && !w_full_reg) begin
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bvalid_reg <= 1'b0;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // An unmapped address answers with an error and writes nothing.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bresp_reg <= PDC_RESP_OKAY;
    end else if (do_write) begin
      bresp_reg <= (wr_kind == PDC_K_NONE) ? PDC_RESP_SLVERR : PDC_RESP_OKAY;
    end
  end

  assign wr_kind  = pdc_decode_kind(aw_addr_reg);
  assign wr_port  = pdc_decode_port(aw_addr_reg);
  assign wr_byte0 = w_strb_reg[0];

  // Bit operation word: bit number, value, port select.
  assign bit_pos  = w_data_reg[PDC_BITOP_POS_LSB +: 3];
  assign bit_val  = w_data_reg[PDC_BITOP_VAL_BIT];
  assign bit_sel  = w_data_reg[PDC_BITOP_SEL_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Direction registers: byte writes through the register itself, bit writes through the
  // bit operation register, which carries port select, bit number and value in one word.
  // A bit write needs both low strobes: the select is in byte 1.
  always_comb begin
    for (int p = 0; p < PDC_NPORT; p++) begin
      dir_next[p] = dir_reg[p];
      if (do_write && wr_byte0 && wr_kind == PDC_K_DIR && wr_port == 3'(p)) begin
        dir_next[p] = s_axi_wdata_mask(w_data_reg[7:0], PDC_IMPL_MASK[p]);
      end else if (do_write && w_strb_reg[1:0] == 2'h3 && wr_kind == PDC_K_BITOP
                   && bit_sel == 3'(p)) begin
        dir_next[p][bit_pos] = bit_val;
      end
      // Forced last, so no write path clears a pinless bit.
      dir_next[p] = dir_next[p] | ~PDC_IMPL_MASK[p];
    end
  end

  // Reset makes every pin an input, safe on any board.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int p = 0; p < PDC_NPORT; p++) begin
        dir_reg[p] <= PDC_DIR_RESET;
      end
    end else begin
      dir_reg <= dir_next;
    end
  end

  // Output latches; bits with no pin stay at zero.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int p = 0; p < PDC_NPORT; p++) begin
        latch_reg[p] <= PDC_LATCH_RESET;
      end
    end else begin
      for (int p = 0; p < PDC_NPORT; p++) begin
        if (do_write && wr_byte0 && wr_kind == PDC_K_LATCH && wr_port == 3'(p)) begin
          latch_reg[p] <= w_data_reg[7:0] & PDC_IMPL_MASK[p];
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pullup_reg <= PDC_PULLUP_RESET;
    end else if (do_write && wr_byte0 && wr_kind == PDC_K_PULLUP) begin
      pullup_reg <= w_data_reg[7:0];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      thresh_reg <= PDC_THRESH_RESET;
    end else if (do_write && wr_byte0 && wr_kind == PDC_K_THRESH) begin
      thresh_reg <= w_data_reg[7:0] & PDC_THRESH_MASK;
    end
  end

  // Byte write of a direction register: pinless bits are forced to one afterwards.
  function automatic logic [7:0] s_axi_wdata_mask(input logic [7:0] d, input logic [7:0] m);
    return d & m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Port 4 pull-up and threshold select only act while the pin is an input; an output pin
  // with a pull-up would waste current against its own driver.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pullup_en_reg <= 8'h00;
    end else begin
      pullup_en_reg <= pullup_reg & dir_reg[0] & PDC_IMPL_MASK[0];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      schmitt3_reg <= 1'b0;
    end else begin
      schmitt3_reg <= thresh_reg[PDC_THRESH_BIT] & dir_reg[0][PDC_THRESH_BIT];
    end
  end

  assign port4_pullup_en         = pullup_en_reg;
  assign port4_pin3_schmitt3_sel = schmitt3_reg;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // One pin cell per port; port 4 has its own pins, the analog ports share a flat bus.
  // Registered cell outputs keep the pads glitch-free.
  generate
    for (genvar p = 0; p < PDC_NPORT; p++) begin : g_port
      if (p == 0) begin : g_p4
        assign cell_in[p] = port4_pins_in;
      end else begin : g_pa
        assign cell_in[p]                 = aport_pins_in[8*(p-1) +: 8];
        assign aport_pins_out[8*(p-1) +: 8]  = cell_out[p];
        assign aport_pins_oe[8*(p-1) +: 8]   = cell_oe[p];
        assign aport_analog_en[8*(p-1) +: 8] = cell_analog[p];
      end

      pdc_pin_cell u_cell (
        .clk        (mclk),
        .rst        (sys_rst),
        .dir        (dir_reg[p]),
        .latch      (latch_reg[p]),
        .impl       (PDC_IMPL_MASK[p]),
        .analog_cap (PDC_ANALOG_MASK[p]),
        .pin_in     (cell_in[p]),
        .pin_out    (cell_out[p]),
        .pin_oe     (cell_oe[p]),
        .analog_en  (cell_analog[p]),
        .read_val   (cell_read[p])
      );
    end
  endgenerate

  // Port 4 has no analog function; its cell's release is unused.
  assign port4_pins_out = cell_out[0];
  assign port4_pins_oe  = cell_oe[0];

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Read channel: one request at a time, answered on the edge that takes it.
  // Arready stays low until rready takes the answer.
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = {24'h000000, rdata_reg};
  assign rd_kind       = pdc_decode_kind(s_axi_araddr);
  assign rd_port       = pdc_decode_port(s_axi_araddr);

  // The bit operation location is write-only and reads zero.
  always_comb begin
    rd_data_next = 8'h00;
    rd_resp_next = PDC_RESP_OKAY;
    unique case (rd_kind)
      PDC_K_DIR:    rd_data_next = dir_reg[rd_port];
      PDC_K_LATCH:  rd_data_next = cell_read[rd_port];
      PDC_K_PULLUP: rd_data_next = pullup_reg;
      PDC_K_THRESH: rd_data_next = thresh_reg;
      PDC_K_BITOP:  rd_data_next = 8'h00;
      default:      rd_resp_next = PDC_RESP_SLVERR;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_reg <= 1'b0;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Loaded only on a taken read, so they stand until rready.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
      rresp_reg <= PDC_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rdata_reg <= rd_data_next;
      rresp_reg <= rd_resp_next;
    end
  end

endmodule
`default_nettype wire

// file: dv/pdc_asserts.sv
// Purpose: Concurrent checks on the port control pins and its register bus.
// Assumes: Bound to every pdc_port_ctrl instance; sees only its ports.
// Notes:   Pin outputs are registered, so the analog checks allow for one cycle of lag after reset.
`timescale 1ns/10ps
`default_nettype none
module pdc_asserts
  import pdc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic [7:0]  port4_pins_oe,
  input wire logic [7:0]  port4_pullup_en,
  input wire logic        port4_pin3_schmitt3_sel,
  input wire logic [47:0] aport_pins_oe,
  input wire logic [47:0] aport_analog_en
);
  localparam logic [47:0] IMPL = {PDC_IMPL_MASK[6], PDC_IMPL_MASK[5], PDC_IMPL_MASK[4],
                                  PDC_IMPL_MASK[3], PDC_IMPL_MASK[2], PDC_IMPL_MASK[1]};
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  AST_RESET_IDLE: assert property (
    $past(sys_rst) |-> port4_pins_oe == 8'h00 && aport_pins_oe == 48'h0)
    else $error("driver enabled right after reset");
  AST_ANALOG_UP: assert property (
    $past(sys_rst, 2) && !$past(sys_rst) |-> aport_analog_en == IMPL)
    else $error("analog pins not released after reset");
  // Every analog port bit with a pin behind it is either driven or released for analog, never both.
  AST_ANALOG_DIR: assert property (
    !$past(sys_rst) |-> (aport_analog_en & aport_pins_oe) == 48'h0
                        && (aport_analog_en | aport_pins_oe) == IMPL)
    else $error("analog release and driver disagree");
  AST_PULLUP_INPUT: assert property (
    (port4_pullup_en & port4_pins_oe) == 8'h00)
    else $error("pull-up on a driven pin");
  AST_SCHMITT_INPUT: assert property (
    port4_pin3_schmitt3_sel |-> !port4_pins_oe[3])
    else $error("threshold select on a driven pin");
  AST_WRITE_ANSWER: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_BVALID_DROP: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_READ_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_RDATA_UPPER: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  cover property (s_axi_bvalid && s_axi_bresp == PDC_RESP_SLVERR);
  cover property (port4_pin3_schmitt3_sel);
  cover property (aport_pins_oe != 48'h0);
endmodule
bind pdc_port_ctrl pdc_asserts pdc_asserts_i (.*);
`default_nettype wire

// file: dv/pdc_pin_board.sv
// Purpose: Board model standing at the port pins.
// Assumes: The bench supplies the level of every pin that nothing drives.
// Notes:   Undriven levels are random each step, so a stale level never passes.
`timescale 1ns/10ps
`default_nettype none
module pdc_pin_board (
  input  wire logic [7:0]  port4_pins_out,
  input  wire logic [7:0]  port4_pins_oe,
  input  wire logic [7:0]  port4_pullup_en,
  input  wire logic [7:0]  ext4,
  input  wire logic [47:0] aport_pins_out,
  input  wire logic [47:0] aport_pins_oe,
  input  wire logic [47:0] exta,
  output logic      [7:0]  port4_pins_in,
  output logic      [47:0] aport_pins_in
);
  // The board never drives against the device, and no shared serial unit runs.
  assign port4_pins_in = (port4_pins_oe & port4_pins_out)
                       | (~port4_pins_oe & (port4_pullup_en | ext4));
  assign aport_pins_in = (aport_pins_oe & aport_pins_out) | (~aport_pins_oe & exta);
endmodule
`default_nettype wire

// file: dv/testbench.sv
// Purpose: Self-checking bench for the port direction control.
// Assumes: Registers are reached over AXI4-Lite; pins see the board model.
// Notes:   A model of every register is kept here and compared after each step.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pdc_pkg::*;
  logic        mclk, sys_rst, aw_ok, w_ok;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d, q;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, port4_pin3_schmitt3_sel;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  port4_pins_in, port4_pins_out, port4_pins_oe, port4_pullup_en, ext4;
  logic [47:0] aport_pins_in, aport_pins_out, aport_pins_oe, aport_analog_en, exta;
  logic [7:0]  dir_m [7];
  logic [7:0]  lat_m [7];
  logic [7:0]  pu_m, th_m;
  int          failures, tests_run, cycles, p;

  pdc_port_ctrl pdc_port_ctrl_i (.*);
  pdc_pin_board pdc_pin_board_i (.*);

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      failures++;
      stop_test();
    end
  end
  ////////////////////////////////////////
  task automatic stop_test();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check_data(input string n, input logic [47:0] e, input logic [47:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic check_resp(input string n, input logic [1:0] e, input logic [1:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [31:0] badr(input logic [31:0] idx);
    return {idx[29:0], 2'h0};
  endfunction

  function automatic logic [7:0] exp_pin(input int n);
    if (n == 0) return (~dir_m[0] & lat_m[0]) | (dir_m[0] & (pu_m | ext4));
    return ~dir_m[n] & lat_m[n];
  endfunction
  ////////////////////////////////////////
  task automatic reg_wr(input logic [31:0] a, input logic [31:0] wd, input logic [3:0] s,
                        input logic [1:0] er);
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge mclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    check_resp("bresp", er, s_axi_bresp);
    s_axi_bready <= 1'b0;
  endtask

  task automatic reg_rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m,
                        input logic [1:0] er);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    check_data("rdata", e & m, s_axi_rdata & m);
    check_resp("rresp", er, s_axi_rresp);
    s_axi_rready <= 1'b0;
  endtask

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      dir_m[i] = 8'hFF;
      lat_m[i] = 8'h00;
    end
    pu_m = 8'h00;
    th_m = 8'h00;
    repeat (3) @(posedge mclk);
  endtask

  task automatic check_pins();
    logic [47:0] ad;
    logic [47:0] al;
    logic [47:0] im;
    logic [7:0]  o4;
    o4 = ~dir_m[0];
    for (int i = 1; i < 7; i++) begin
      ad[i*8-8 +: 8] = dir_m[i];
      al[i*8-8 +: 8] = lat_m[i];
      im[i*8-8 +: 8] = PDC_IMPL_MASK[i];
    end
    check_data("p4_oe", o4, port4_pins_oe);
    check_data("p4_out", o4 & lat_m[0], port4_pins_out & port4_pins_oe);
    check_data("p4_pullup", pu_m & dir_m[0], port4_pullup_en);
    check_data("schmitt", th_m[3] & dir_m[0][3], port4_pin3_schmitt3_sel);
    check_data("a_oe", ~ad & im, aport_pins_oe);
    check_data("a_analog", ad & im, aport_analog_en);
    check_data("a_out", ~ad & al & im, aport_pins_out & aport_pins_oe);
  endtask
  ////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    ext4 = 8'h00;
    exta = 48'h0;
    failures = 0;
    tests_run = 0;
    q = $urandom(32'h1ABD9B06);
    do_reset();
    check_pins();
    for (p = 0; p < 7; p++) reg_rd(badr(PDC_DIR_IDX[p]), 32'hFF, 32'hFF, PDC_RESP_OKAY);
    reg_wr(32'h0, 32'hFF, 4'hF, PDC_RESP_SLVERR);
    reg_rd(32'h0, 32'h0, 32'hFFFFFFFF, PDC_RESP_SLVERR);
    reg_wr(badr(PDC_DIR_IDX[1]), 32'h0, 4'hE, PDC_RESP_OKAY);
    reg_wr(badr(PDC_BITOP_IDX), 32'h00000700, 4'h3, PDC_RESP_OKAY);
    reg_wr(badr(PDC_BITOP_IDX), 32'h00000100, 4'h3, PDC_RESP_OKAY);
    reg_rd(badr(PDC_DIR_IDX[1]), 32'hFF, 32'hFF, PDC_RESP_OKAY);
    check_pins();
    for (int i = 0; i < 80; i++) begin
      p = $urandom_range(6);
      d = $urandom;
      ext4 <= 8'($urandom);
      exta <= 48'({$urandom, $urandom});
      case ($urandom_range(3))
        0: begin
          reg_wr(badr(PDC_DIR_IDX[p]), {24'h0, d[7:0]}, 4'hF, PDC_RESP_OKAY);
          dir_m[p] = d[7:0] | ~PDC_IMPL_MASK[p];
        end
        1: begin
          reg_wr(badr(PDC_BITOP_IDX), {21'h0, 3'(p), 4'h0, d[3:0]}, 4'h3, PDC_RESP_OKAY);
          dir_m[p][d[2:0]] = d[3] | ~PDC_IMPL_MASK[p][d[2:0]];
        end
        2: begin
          reg_wr(badr(PDC_LATCH_IDX[p]), {24'h0, d[7:0]}, 4'hF, PDC_RESP_OKAY);
          lat_m[p] = d[7:0];
        end
        default: begin
          reg_wr(badr(PDC_PULLUP_IDX), {24'h0, d[7:0]}, 4'hF, PDC_RESP_OKAY);
          reg_wr(badr(PDC_THRESH_IDX), {24'h0, d[15:8]}, 4'hF, PDC_RESP_OKAY);
          pu_m = d[7:0];
          th_m = d[15:8] & PDC_THRESH_MASK;
          reg_rd(badr(PDC_THRESH_IDX), {24'h0, th_m}, 32'hFF, PDC_RESP_OKAY);
        end
      endcase
      repeat (3) @(posedge mclk);
      check_pins();
      reg_rd(badr(PDC_DIR_IDX[p]), {24'h0, dir_m[p]}, 32'hFF, PDC_RESP_OKAY);
      reg_rd(badr(PDC_LATCH_IDX[p]), {24'h0, exp_pin(p)}, {24'h0, PDC_IMPL_MASK[p]},
             PDC_RESP_OKAY);
    end
    reg_wr(badr(PDC_DIR_IDX[3]), 32'h0, 4'hF, PDC_RESP_OKAY);
    do_reset();
    check_pins();
    reg_rd(badr(PDC_DIR_IDX[3]), 32'hFF, 32'hFF, PDC_RESP_OKAY);
    stop_test();
  end
endmodule
`default_nettype wire
